// ### inc/nmse_params.svh
// Register addresses, field positions, codes and reset values of the NVM block
`ifndef NMSE_PARAMS_SVH
`define NMSE_PARAMS_SVH

// Register byte addresses on the register port
`define NMSE_REG_CFG 16'h3001
`define NMSE_REG_COBIX 16'h3002
`define NMSE_REG_ECFG 16'h3003
`define NMSE_REG_ESTAT 16'h3004
`define NMSE_REG_STAT 16'h3005
`define NMSE_REG_COBHI 16'h3006
`define NMSE_REG_COBLO 16'h3007
`define NMSE_REG_PROT 16'h3008
`define NMSE_REG_SEC 16'hFF7F

// Flash configuration field holding the backdoor keys
`define NMSE_KEY_BASE 16'hFF70
`define NMSE_KEY_CNT 4'h8
`define NMSE_KEY_LAST 3'h7

// Status, config and ECC register bits
`define NMSE_STAT_COMPLETE 7
`define NMSE_STAT_ACCESS_ERR 5
`define NMSE_STAT_PROT_VIOL 4
`define NMSE_CFG_IGNORE_SF 4
`define NMSE_ECFG_DBL_IE 1
`define NMSE_ECFG_SGL_IE 0
`define NMSE_ESTAT_DBL 1
`define NMSE_ESTAT_SGL 0

// Protection register layout and reset value
`define NMSE_PROT_REST 7
`define NMSE_PROT_HDIS 5
`define NMSE_PROT_HS_HI 4
`define NMSE_PROT_HS_LO 3
`define NMSE_PROT_LDIS 2
`define NMSE_PROT_LS_HI 1
`define NMSE_PROT_LS_LO 0
`define NMSE_PROT_RST 8'h24
`define NMSE_HI_END 16'hFFFF
`define NMSE_HI_UNIT 16'h0800
`define NMSE_LO_BASE 16'h8000
`define NMSE_LO_UNIT 16'h0400

// Security byte
`define NMSE_SEC_RST 8'hFF
`define NMSE_SEC_UNSEC 2'h2
`define NMSE_KEY_ENABLE 2'h2

// Command codes and command word layout
`define NMSE_CMD_MARGIN 8'h0D
`define NMSE_CMD_VERIFY_KEY 8'h0C
`define NMSE_CMD_PROG_FLASH 8'h06
`define NMSE_CMD_ERASE_SECTOR 8'h0A
`define NMSE_MARGIN_ZERO 16'h0002
`define NMSE_TARGET_EE 7
`define NMSE_INDEX_CMD 3'h0
`define NMSE_INDEX_ADDR 3'h1
`define NMSE_INDEX_LEVEL 3'h2
`define NMSE_INDEX_KEYS 3'h1
`define NMSE_COB_LAST 3'h5

`endif

// ### inc/nmse_pkg.sv
// Types shared by the NVM block: controller states and state records
package nmse_pkg;

    typedef enum logic [4:0] {
        ST_INIT = 5'h01,
        ST_IDLE = 5'h02,
        ST_EXEC = 5'h04,
        ST_KEY = 5'h08,
        ST_WOP = 5'h10
    } nmse_state_e;

    typedef struct packed {
        nmse_state_e st;
        logic command_complete_flag;
        logic accerr;
        logic protection_violation_flag;
        logic [3:0] cnt;
        logic pend;
        logic [3:0] pidx;
        logic mism;
        logic launch_dbg;
        logic bd_unsec;
        logic [7:0] sec;
        logic [2:0] cobix;
        logic [5:0][15:0] cob;
        logic ignore_single_fault;
        logic dfd_ie;
        logic sfd_ie;
        logic dff;
        logic sff;
        logic [7:0] prot;
        logic [1:0] fl_margin;
        logic [1:0] ee_margin;
        logic [7:0] rdata;
        logic [7:0] ee_data;
        logic op_req;
    } nmse_ctrl_s;

    typedef struct packed {
        logic [7:0][7:0] mem;
        logic [7:0] rdata;
    } nmse_keymem_s;

endpackage

// ### rtl/nmse_ecc_dec.sv
// EEPROM ECC decoder: corrects one bit, flags two
module nmse_ecc_dec (
    input wire logic [12:0] code_in,
    output logic [7:0] data_out,
    output logic single_out,
    output logic double_out
);
    // Hamming positions 1..12 in bits 11:0, overall parity in bit 12
    always_comb begin
        logic [3:0] syn;
        logic [11:0] fixed;
        logic par;
        int j;
        syn = 4'h0;
        j = 0;
        par = ^code_in;
        fixed = code_in[11:0];
        data_out = 8'h00;
        for (int p = 1; p <= 12; p++) begin
            if (code_in[p - 1]) begin
                syn = syn ^ 4'(p);
            end
        end
        // Odd parity with syndrome up to 12 means one flipped bit; otherwise a nonzero syndrome means two
        single_out = par && (syn <= 4'hC);
        double_out = (!par && (syn != 4'h0)) || (par && (syn > 4'hC));
        if (single_out && (syn != 4'h0)) begin
            fixed[syn - 4'h1] = !fixed[syn - 4'h1];
        end
        // Data bits sit at the positions that are not powers of two
        for (int p = 1; p <= 12; p++) begin
            if ((p & (p - 1)) != 0) begin
                data_out[j[2:0]] = fixed[p - 1];
                j = j + 1;
            end
        end
    end
endmodule

// ### rtl/nmse_key_mem.sv
// Backdoor key store, eight bytes, registered read
module nmse_key_mem (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic wr_en_in,
    input wire logic [2:0] wr_idx_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [2:0] rd_idx_in,
    output logic [7:0] rd_data_out
);
    nmse_pkg::nmse_keymem_s q;
    nmse_pkg::nmse_keymem_s d;

    // Write port and registered read port
    always_comb begin
        d = q;
        if (wr_en_in) begin
            d.mem[wr_idx_in] = wr_data_in;
        end
        d.rdata = q.mem[rd_idx_in];
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else if (ce_in) begin
            q <= d;
        end
    end

    assign rd_data_out = q.rdata;
endmodule

// ### rtl/nmse_ctrl.sv
// NVM controller: margin, security, backdoor keys, ECC flags, protection
//
// Contract
// - Two read margin levels, applied to array
// - Margin command code 0x0D in word 0
// - Low byte bit 7 picks EEPROM
// - Word 1 address, word 2 level code
// - Launch by 0x80, complete flag when done
// - Security bits 0b10 unsecured, else secured
// - Backdoor keys enabled only when bits 7:6=0b10
// - Eight matching keys unsecure the device
// - Backdoor unsecure lasts until next reset or a failed key verify
// - No keys through the debug port
// - EEPROM reads corrected single, detected double
// - Double flag always, single unless ignored
// - Each flag has its own enabled interrupt
// - Fault flags update one cycle after read
// - Protected program or erase sets violation
// - Low range up, high range down, rest
// - Protection writes may only enlarge it; code accepts resizing a disabled window, which can shrink rest
// - High 2-16 KB, low 1-8 KB
`include "nmse_params.svh"
module nmse_ctrl (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic dbg_access_in,
    output logic [7:0] reg_rdata_out,
    output logic flash_rd_out,
    output logic [15:0] flash_addr_out,
    input wire logic [7:0] flash_rdata_in,
    output logic flash_op_req_out,
    output logic [7:0] flash_op_code_out,
    output logic [15:0] flash_op_addr_out,
    input wire logic flash_op_done_in,
    input wire logic ee_rd_valid_in,
    input wire logic [12:0] ee_code_in,
    output logic [7:0] ee_rdata_out,
    output logic [1:0] flash_margin_out,
    output logic [1:0] ee_margin_out,
    output logic secure_out,
    output logic ecc_dbl_irq_out,
    output logic ecc_sgl_irq_out
);
    nmse_pkg::nmse_ctrl_s q;
    nmse_pkg::nmse_ctrl_s d;
    logic km_wr;
    logic [2:0] km_ridx;
    logic [7:0] km_rdata;
    logic [7:0] ecc_data;
    logic ecc_sgl;
    logic ecc_dbl;
    logic [7:0] rd_mux;
    logic [7:0] cmd_w;
    logic hit_w;

    // Address falls in an active protection window
    function automatic logic prot_hit(input logic [15:0] a,
                                      input logic [7:0] p);
        logic [15:0] hi_start;
        logic [15:0] lo_end;
        logic in_hi;
        logic in_lo;
        hi_start = `NMSE_HI_END - ((`NMSE_HI_UNIT
            << p[`NMSE_PROT_HS_HI:`NMSE_PROT_HS_LO]) - 16'h0001);
        lo_end = `NMSE_LO_BASE
            + (`NMSE_LO_UNIT << p[`NMSE_PROT_LS_HI:`NMSE_PROT_LS_LO]);
        in_hi = a >= hi_start;
        in_lo = (a >= `NMSE_LO_BASE) && (a < lo_end);
        prot_hit = (!p[`NMSE_PROT_HDIS] && in_hi)
            || (!p[`NMSE_PROT_LDIS] && in_lo)
            || (p[`NMSE_PROT_REST] && (a >= `NMSE_LO_BASE)
                && !in_hi && !in_lo);
    endfunction

    // New setting keeps each enabled window enabled and no smaller, and keeps rest set
    function automatic logic prot_grows(input logic [7:0] n,
                                        input logic [7:0] o);
        prot_grows = (o[`NMSE_PROT_HDIS] || (!n[`NMSE_PROT_HDIS]
              && n[`NMSE_PROT_HS_HI:`NMSE_PROT_HS_LO]
              >= o[`NMSE_PROT_HS_HI:`NMSE_PROT_HS_LO]))
            && (o[`NMSE_PROT_LDIS] || (!n[`NMSE_PROT_LDIS]
              && n[`NMSE_PROT_LS_HI:`NMSE_PROT_LS_LO]
              >= o[`NMSE_PROT_LS_HI:`NMSE_PROT_LS_LO]))
            && (!o[`NMSE_PROT_REST] || n[`NMSE_PROT_REST]);
    endfunction

    // Supplied key byte k: even keys in high byte of each word
    function automatic logic [7:0] key_byte(input logic [5:0][15:0] cob,
                                            input logic [2:0] k);
        logic [15:0] w;
        w = cob[`NMSE_INDEX_KEYS + {1'b0, k[2:1]}];
        key_byte = k[0] ? w[7:0] : w[15:8];
    endfunction

    nmse_key_mem u_key_mem (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .wr_en_in(km_wr),
        .wr_idx_in(q.pidx[2:0]),
        .wr_data_in(flash_rdata_in),
        .rd_idx_in(km_ridx),
        .rd_data_out(km_rdata)
    );

    nmse_ecc_dec u_ecc_dec (
        .code_in(ee_code_in),
        .data_out(ecc_data),
        .single_out(ecc_sgl),
        .double_out(ecc_dbl)
    );

    assign cmd_w = q.cob[`NMSE_INDEX_CMD][15:8];
    assign hit_w = prot_hit(q.cob[`NMSE_INDEX_ADDR], q.prot);
    assign km_ridx = q.cnt[2:0];

    // Register read multiplexer
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr_in == `NMSE_REG_STAT) begin
            rd_mux[`NMSE_STAT_COMPLETE] = q.command_complete_flag;
            rd_mux[`NMSE_STAT_ACCESS_ERR] = q.accerr;
            rd_mux[`NMSE_STAT_PROT_VIOL] = q.protection_violation_flag;
        end else if (reg_addr_in == `NMSE_REG_COBIX) begin
            rd_mux[2:0] = q.cobix;
        end else if (reg_addr_in == `NMSE_REG_COBHI) begin
            rd_mux = q.cob[q.cobix][15:8];
        end else if (reg_addr_in == `NMSE_REG_COBLO) begin
            rd_mux = q.cob[q.cobix][7:0];
        end else if (reg_addr_in == `NMSE_REG_CFG) begin
            rd_mux[`NMSE_CFG_IGNORE_SF] = q.ignore_single_fault;
        end else if (reg_addr_in == `NMSE_REG_ECFG) begin
            rd_mux[`NMSE_ECFG_DBL_IE] = q.dfd_ie;
            rd_mux[`NMSE_ECFG_SGL_IE] = q.sfd_ie;
        end else if (reg_addr_in == `NMSE_REG_ESTAT) begin
            rd_mux[`NMSE_ESTAT_DBL] = q.dff;
            rd_mux[`NMSE_ESTAT_SGL] = q.sff;
        end else if (reg_addr_in == `NMSE_REG_PROT) begin
            rd_mux = q.prot;
        end else if (reg_addr_in == `NMSE_REG_SEC) begin
            rd_mux = q.sec;
        end
    end

    // Next state: bus writes first, hardware events after so sets win
    always_comb begin
        logic miss;
        logic open;
        miss = 1'b0;
        open = q.command_complete_flag && (q.st == nmse_pkg::ST_IDLE);
        d = q;
        d.op_req = 1'b0;
        km_wr = 1'b0;
        if (reg_rd_in) begin
            d.rdata = rd_mux;
        end
        if (reg_wr_in) begin
            if (reg_addr_in == `NMSE_REG_STAT) begin
                if (reg_wdata_in[`NMSE_STAT_ACCESS_ERR]) begin
                    d.accerr = 1'b0;
                end
                if (reg_wdata_in[`NMSE_STAT_PROT_VIOL]) begin
                    d.protection_violation_flag = 1'b0;
                end
                if (reg_wdata_in[`NMSE_STAT_COMPLETE] && open) begin
                    d.command_complete_flag = 1'b0;
                    d.st = nmse_pkg::ST_EXEC;
                    d.launch_dbg = dbg_access_in;
                end
            end else if (reg_addr_in == `NMSE_REG_COBIX) begin
                if (open) begin
                    d.cobix = reg_wdata_in[2:0];
                end
            end else if (reg_addr_in == `NMSE_REG_COBHI) begin
                if (open && q.cobix <= `NMSE_COB_LAST) begin
                    d.cob[q.cobix][15:8] = reg_wdata_in;
                end
            end else if (reg_addr_in == `NMSE_REG_COBLO) begin
                if (open && q.cobix <= `NMSE_COB_LAST) begin
                    d.cob[q.cobix][7:0] = reg_wdata_in;
                end
            end else if (reg_addr_in == `NMSE_REG_CFG) begin
                d.ignore_single_fault = reg_wdata_in[`NMSE_CFG_IGNORE_SF];
            end else if (reg_addr_in == `NMSE_REG_ECFG) begin
                d.dfd_ie = reg_wdata_in[`NMSE_ECFG_DBL_IE];
                d.sfd_ie = reg_wdata_in[`NMSE_ECFG_SGL_IE];
            end else if (reg_addr_in == `NMSE_REG_ESTAT) begin
                if (reg_wdata_in[`NMSE_ESTAT_DBL]) begin
                    d.dff = 1'b0;
                end
                if (reg_wdata_in[`NMSE_ESTAT_SGL]) begin
                    d.sff = 1'b0;
                end
            end else if (reg_addr_in == `NMSE_REG_PROT) begin
                if (prot_grows(reg_wdata_in, q.prot)) begin
                    d.prot = reg_wdata_in;
                end
            end
        end
        // EEPROM read: data and fault flags land one cycle later
        if (ee_rd_valid_in) begin
            d.ee_data = ecc_data;
            if (ecc_dbl) begin
                d.dff = 1'b1;
            end
            if (ecc_sgl && !q.ignore_single_fault) begin
                d.sff = 1'b1;
            end
        end
        case (q.st)
            nmse_pkg::ST_INIT: begin
                // Fetch the eight keys, then the security byte
                d.pend = q.cnt <= `NMSE_KEY_CNT;
                if (q.cnt <= `NMSE_KEY_CNT) begin
                    d.cnt = q.cnt + 4'h1;
                    d.pidx = q.cnt;
                end
                if (q.pend && q.pidx == `NMSE_KEY_CNT) begin
                    d.sec = flash_rdata_in;
                    d.st = nmse_pkg::ST_IDLE;
                    d.command_complete_flag = 1'b1;
                    d.pend = 1'b0;
                end else if (q.pend) begin
                    km_wr = 1'b1;
                end
            end
            nmse_pkg::ST_EXEC: begin
                d.cnt = 4'h0;
                d.pend = 1'b0;
                d.mism = 1'b0;
                d.command_complete_flag = 1'b1;
                d.st = nmse_pkg::ST_IDLE;
                if (cmd_w == `NMSE_CMD_MARGIN) begin
                    if (q.cob[`NMSE_INDEX_LEVEL] > `NMSE_MARGIN_ZERO) begin
                        d.accerr = 1'b1;
                    end else if (q.cob[`NMSE_INDEX_CMD][`NMSE_TARGET_EE]) begin
                        d.ee_margin = q.cob[`NMSE_INDEX_LEVEL][1:0];
                    end else begin
                        d.fl_margin = q.cob[`NMSE_INDEX_LEVEL][1:0];
                    end
                end else if (cmd_w == `NMSE_CMD_VERIFY_KEY) begin
                    if (q.launch_dbg || q.sec[7:6] != `NMSE_KEY_ENABLE) begin
                        d.accerr = 1'b1;
                    end else begin
                        d.command_complete_flag = 1'b0;
                        d.st = nmse_pkg::ST_KEY;
                    end
                end else if (cmd_w == `NMSE_CMD_PROG_FLASH
                             || cmd_w == `NMSE_CMD_ERASE_SECTOR) begin
                    if (hit_w) begin
                        d.protection_violation_flag = 1'b1;
                    end else begin
                        d.command_complete_flag = 1'b0;
                        d.op_req = 1'b1;
                        d.st = nmse_pkg::ST_WOP;
                    end
                end else begin
                    d.accerr = 1'b1;
                end
            end
            nmse_pkg::ST_KEY: begin
                // Compare stored keys one by one against supplied ones
                d.pend = q.cnt < `NMSE_KEY_CNT;
                if (q.cnt < `NMSE_KEY_CNT) begin
                    d.cnt = q.cnt + 4'h1;
                    d.pidx = q.cnt;
                end
                if (q.pend) begin
                    miss = km_rdata != key_byte(q.cob, q.pidx[2:0]);
                    d.mism = q.mism || miss;
                    if (q.pidx[2:0] == `NMSE_KEY_LAST) begin
                        d.bd_unsec = !(q.mism || miss);
                        d.accerr = d.accerr || q.mism || miss;
                        d.command_complete_flag = 1'b1;
                        d.pend = 1'b0;
                        d.st = nmse_pkg::ST_IDLE;
                    end
                end
            end
            nmse_pkg::ST_WOP: begin
                if (flash_op_done_in) begin
                    d.command_complete_flag = 1'b1;
                    d.st = nmse_pkg::ST_IDLE;
                end
            end
            default: begin
            end
        endcase
    end

    // State register; reset drops any backdoor unsecure
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.st <= nmse_pkg::ST_INIT;
            q.sec <= `NMSE_SEC_RST;
            q.prot <= `NMSE_PROT_RST;
        end else if (ce_in) begin
            q <= d;
        end
    end

    // Outputs
    assign reg_rdata_out = q.rdata;
    assign flash_rd_out = (q.st == nmse_pkg::ST_INIT)
        && (q.cnt <= `NMSE_KEY_CNT);
    assign flash_addr_out = (q.cnt == `NMSE_KEY_CNT) ? `NMSE_REG_SEC
        : `NMSE_KEY_BASE + {12'h000, q.cnt};
    assign flash_op_req_out = q.op_req;
    assign flash_op_code_out = cmd_w;
    assign flash_op_addr_out = q.cob[`NMSE_INDEX_ADDR];
    assign ee_rdata_out = q.ee_data;
    assign flash_margin_out = q.fl_margin;
    assign ee_margin_out = q.ee_margin;
    assign secure_out = (q.sec[1:0] != `NMSE_SEC_UNSEC) && !q.bd_unsec;
    assign ecc_dbl_irq_out = q.dff && q.dfd_ie;
    assign ecc_sgl_irq_out = q.sff && q.sfd_ie;

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_launch;
        ce_in && reg_wr_in && reg_addr_in == `NMSE_REG_STAT
            && reg_wdata_in[`NMSE_STAT_COMPLETE] && q.command_complete_flag
            && q.st == nmse_pkg::ST_IDLE;
    endsequence
    sequence s_margin(logic ee);
        ce_in && q.st == nmse_pkg::ST_EXEC && cmd_w == `NMSE_CMD_MARGIN
            && q.cob[`NMSE_INDEX_LEVEL] == `NMSE_MARGIN_ZERO
            && q.cob[`NMSE_INDEX_CMD][`NMSE_TARGET_EE] == ee;
    endsequence

    a_launch_busy: assert property (s_launch |=> !q.command_complete_flag
        && q.st == nmse_pkg::ST_EXEC) else $error("launch not taken");
    a_margin_ee: assert property (s_margin(1'b1) |=> q.command_complete_flag
        && ee_margin_out == `NMSE_MARGIN_ZERO
        && $stable(flash_margin_out)) else $error("ee margin wrong");
    a_margin_fl: assert property (s_margin(1'b0) |=> q.command_complete_flag
        && flash_margin_out == `NMSE_MARGIN_ZERO
        && $stable(ee_margin_out)) else $error("flash margin wrong");
    a_secure_map: assert property (!q.bd_unsec
        |-> secure_out == (q.sec[1:0] != `NMSE_SEC_UNSEC))
        else $error("security state mismatch");
    a_key_gate: assert property (ce_in && q.st == nmse_pkg::ST_EXEC
        && cmd_w == `NMSE_CMD_VERIFY_KEY && (q.launch_dbg
        || q.sec[7:6] != `NMSE_KEY_ENABLE) |=> q.accerr && q.command_complete_flag
        && $stable(q.bd_unsec)) else $error("key access not refused");
    a_unsec_cause: assert property ($rose(q.bd_unsec)
        |-> $past(q.st) == nmse_pkg::ST_KEY && q.command_complete_flag && !q.mism)
        else $error("unsecure without key match");
    a_dbl_flag: assert property (ce_in && ee_rd_valid_in && ecc_dbl
        |=> q.dff ##0 (ecc_dbl_irq_out == q.dfd_ie))
        else $error("double fault flag late");
    a_sgl_ignore: assert property (ce_in && ee_rd_valid_in && ecc_sgl
        && q.ignore_single_fault && !q.sff |=> !q.sff) else $error("ignored single set");
    a_prot_viol: assert property (ce_in && q.st == nmse_pkg::ST_EXEC
        && (cmd_w == `NMSE_CMD_PROG_FLASH
        || cmd_w == `NMSE_CMD_ERASE_SECTOR) && hit_w
        |=> q.protection_violation_flag && !flash_op_req_out && q.command_complete_flag)
        else $error("protected op not stopped");
    a_prot_grow: assert property (ce_in |=>
        prot_grows(q.prot, $past(q.prot))) else $error("protection shrank");
endmodule

// ### tb/nmse_ctrl_bench.sv
// Self-checking bench of the NVM controller through its register port
`include "nmse_params.svh"
`define CHK(n, e, a) begin \
    compares++; \
    if ((a) !== (e)) begin \
        err_count++; \
        $display("MISMATCH %s exp %0h got %0h", n, e, a); \
    end \
end
module nmse_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] KEYS = 64'h1122334455667788;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic dbg = 1'b0;
    logic done = 1'b0;
    logic ee_v = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] fsec = 8'hBE;
    logic [12:0] ee_code = 13'h0000;
    logic [23:0] lastop = 24'h000000;
    logic [7:0] rdata, fdata, eedata, opc, st;
    logic [15:0] faddr, opa;
    logic frd, opreq, sec, dirq, sirq;
    logic [1:0] fm, em;
    int err_count = 0;
    int compares = 0;
    int opcnt = 0;
    int cyc = 0;

    // Clock; config field answers one cycle after each read request
    always #5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        fdata <= !frd ? 8'hFF : faddr == `NMSE_REG_SEC ? fsec :
            faddr[15:3] == 13'h1FEE ? KEYS[63 - 8 * faddr[2:0] -: 8] : 8'hFF;
    end

    nmse_ctrl uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
        .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_wdata_in(wdata), .dbg_access_in(dbg), .reg_rdata_out(rdata),
        .flash_rd_out(frd), .flash_addr_out(faddr), .flash_rdata_in(fdata),
        .flash_op_req_out(opreq), .flash_op_code_out(opc),
        .flash_op_addr_out(opa), .flash_op_done_in(done),
        .ee_rd_valid_in(ee_v), .ee_code_in(ee_code), .ee_rdata_out(eedata),
        .flash_margin_out(fm), .ee_margin_out(em), .secure_out(sec),
        .ecc_dbl_irq_out(dirq), .ecc_sgl_irq_out(sirq));

    // Array answers each op one cycle later; cycle ceiling
    always @(posedge clock_in) begin
        done <= opreq;
        if (opreq) begin
            opcnt++;
            lastop <= {opc, opa};
        end
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    task results;
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock_in);
        reg_wr <= 1'b0;
        @(posedge clock_in);
    endtask

    task rd(input logic [15:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock_in);
        reg_rd <= 1'b0;
        @(posedge clock_in);
        d = rdata;
    endtask

    task word(input int i, input logic [15:0] w);
        wr(`NMSE_REG_COBIX, 8'(i));
        wr(`NMSE_REG_COBHI, w[15:8]);
        wr(`NMSE_REG_COBLO, w[7:0]);
    endtask

    // Launch and poll the complete flag, bounded
    task go(output logic [7:0] s);
        wr(`NMSE_REG_STAT, 8'h80);
        s = 8'h00;
        for (int n = 0; n < 40 && s[7] !== 1'b1; n++) rd(`NMSE_REG_STAT, s);
    endtask

    task rst_dut;
        rst_n_in <= 1'b0;
        repeat (16) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (12) @(posedge clock_in);
    endtask

    task vkey(input logic [63:0] k);
        word(0, {`NMSE_CMD_VERIFY_KEY, 8'h00});
        for (int i = 1; i < 5; i++) word(i, k[79 - 16 * i -: 16]);
        go(st);
        wr(`NMSE_REG_STAT, 8'h30);
    endtask

    task cmd(input logic [7:0] c, input logic [15:0] a, input logic v);
        int n;
        n = opcnt;
        word(0, {c, 8'h00});
        word(1, a);
        go(st);
        `CHK("violation", v, st[4])
        `CHK("op count", n + int'(!v), opcnt)
        if (!v) `CHK("op", {c, a}, lastop)
        wr(`NMSE_REG_STAT, 8'h30);
    endtask

    task ee(input logic [12:0] c);
        ee_code <= c;
        ee_v <= 1'b1;
        @(posedge clock_in);
        ee_v <= 1'b0;
        @(posedge clock_in);
    endtask

    // Hamming code over positions 1..12 plus overall even parity
    function automatic logic [12:0] enc(input logic [7:0] d);
        logic [12:0] c;
        c = 13'h0000;
        {c[11], c[10], c[9], c[8], c[6], c[5], c[4], c[2]} = d;
        for (int i = 1; i <= 8; i = i * 2) begin
            for (int j = 1; j <= 12; j++) begin
                if ((j & i) != 0 && j != i) c[i - 1] ^= c[j - 1];
            end
        end
        c[12] = ^c[11:0];
        return c;
    endfunction

    // Main sequence
    initial begin
        rst_dut();
        rd(`NMSE_REG_PROT, st);
        `CHK("prot reset", `NMSE_PROT_RST, st)
        rd(`NMSE_REG_SEC, st);
        `CHK("sec byte", 8'hBE, st)
        `CHK("unsecured", 1'b0, sec)
        // Margin on each array, levels 1, 2 and an illegal 3
        for (int t = 0; t < 2; t++) begin
            for (int lv = 1; lv < 4; lv++) begin
                word(0, {`NMSE_CMD_MARGIN, t[0], 7'h00});
                word(1, 16'h3100);
                word(2, 16'(lv));
                go(st);
                `CHK("done", 1'b1, st[7])
                `CHK("level err", lv == 3, st[5])
                wr(`NMSE_REG_STAT, 8'h30);
                `CHK("margin", 2'(lv < 3 ? lv : 2), t ? em : fm)
                `CHK("other", 2'(t ? 2 : 0), t ? fm : em)
            end
        end
        // ECC flags and interrupts
        wr(`NMSE_REG_ECFG, 8'h03);
        ee(enc(8'hA5));
        `CHK("clean", {8'hA5, 2'b00}, {eedata, sirq, dirq})
        ee(enc(8'hA5) ^ 13'h0010);
        `CHK("single", {8'hA5, 2'b10}, {eedata, sirq, dirq})
        wr(`NMSE_REG_ESTAT, 8'h03);
        `CHK("cleared", 1'b0, sirq)
        wr(`NMSE_REG_CFG, 8'h10);
        ee(enc(8'h3C) ^ 13'h0400);
        `CHK("ignored", {8'h3C, 2'b00}, {eedata, sirq, dirq})
        ee(enc(8'h3C) ^ 13'h0003);
        `CHK("double", 1'b1, dirq)
        wr(`NMSE_REG_ECFG, 8'h01);
        `CHK("masked", 1'b0, dirq)
        // Protection ranges, growth only
        wr(`NMSE_REG_PROT, 8'h04);
        cmd(`NMSE_CMD_PROG_FLASH, 16'hF800, 1'b1);
        cmd(`NMSE_CMD_PROG_FLASH, 16'hF7FC, 1'b0);
        wr(`NMSE_REG_PROT, `NMSE_PROT_RST);
        rd(`NMSE_REG_PROT, st);
        `CHK("no shrink", 8'h04, st)
        wr(`NMSE_REG_PROT, 8'h18);
        rd(`NMSE_REG_PROT, st);
        `CHK("grow", 8'h18, st)
        cmd(`NMSE_CMD_PROG_FLASH, 16'hC000, 1'b1);
        cmd(`NMSE_CMD_ERASE_SECTOR, 16'hBE00, 1'b0);
        cmd(`NMSE_CMD_PROG_FLASH, 16'h83FC, 1'b1);
        cmd(`NMSE_CMD_ERASE_SECTOR, 16'h8400, 1'b0);
        // Backdoor keys
        fsec <= 8'hBC;
        rst_dut();
        `CHK("secured", 1'b1, sec)
        cmd(`NMSE_CMD_ERASE_SECTOR, 16'hFE00, 1'b0);
        cmd(`NMSE_CMD_PROG_FLASH, 16'hFF7C, 1'b0);
        dbg <= 1'b1;
        vkey(KEYS);
        dbg <= 1'b0;
        `CHK("debug keys", 1'b1, sec)
        vkey(KEYS ^ 64'h1);
        `CHK("bad keys", 1'b1, sec)
        vkey(KEYS);
        `CHK("good keys", 1'b0, sec)
        rst_dut();
        `CHK("relocked", 1'b1, sec)
        fsec <= 8'h3C;
        rst_dut();
        vkey(KEYS);
        `CHK("keys off", 1'b1, sec)
        for (int p = 0; p < 4; p++) begin
            fsec <= {6'h2F, 2'(p)};
            rst_dut();
            `CHK("sec bits", p != 2, sec)
        end
        results();
    end
endmodule
